// >>> verilog/modem_control_lines.sv
/*
  Modem-control register with transmit-edge select, request/clear-to-send
  handshake and two general-purpose direction-programmable modem pins.
  Assumes one 40 MHz clock; the transmit clock and both modem pins come
  from outside and are synchronised here. The framer supplies the
  transmit bit, frame status and the mode word.
*/
// Design decisions made here: the register addresses and the strobed register port.
// Overview of operation
// - Register selected when pointer bits 3:1 equal 5
// - Edge bit set: data changes on rising edge
// - Handshake bit makes pins request output and clear input
// - Request low while data waits or sends
// - After closing flag, release request when idle/spaced
// - Handshake off: pins are general modem I/O
// - Terminal-ready direction bit: input or output
// - Set-ready direction bit: input or output
// - Terminal-ready value reads pin when input
// - Terminal-ready value written drives pin when output
// - Set-ready value reads pin or drives it
// - Spacing comes from mode word bits 15:11
`include "modem_control_map.svh"
`default_nettype none

module modem_control_lines (
  // Clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        rst_n_i,
  // Register port
  input  wire modem_control_pkg::bus_req_t bus_i,
  output logic [`REG_W-1:0]                rd_data_o,
  // Framer side
  input  wire logic                        tx_bit_i,
  input  wire logic                        tx_pending_i,
  input  wire logic                        closing_flag_i,
  input  wire logic                        frame_waiting_i,
  input  wire logic [`REG_W-1:0]           mode_word_i,
  output logic                             tx_permit_o,
  output logic                             tx_bit_taken_o,
  // Transmit clock pin
  input  wire logic                        tx_clock_i,
  // Serial data pin
  output logic                             serial_tx_data_o,
  // Terminal-ready / request pin
  input  wire logic                        pin_a_i,
  output logic                             pin_a_o,
  output logic                             pin_a_oe_o,
  // Set-ready / clear pin
  input  wire logic                        pin_b_i,
  output logic                             pin_b_o,
  output logic                             pin_b_oe_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic spacing_over_two(
    input logic [`MFS_W-1:0] code
  );
    spacing_over_two = (code != `MFS_CODE_ONE) &&
                       (code != `MFS_CODE_TWO);
  endfunction

  function automatic logic pick_pin(
    input logic dir,
    input logic val,
    input logic pin
  );
    pick_pin = dir ? val : pin;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  modem_control_pkg::state_t state_reg;
  modem_control_pkg::state_t state_next;

  logic                      sel;
  logic                      wr_hit;
  logic                      rd_hit;
  logic                      clk_rise;
  logic                      clk_fall;
  logic                      tx_edge;
  logic                      cts_low;
  logic                      release_req;
  logic                      permit;
  logic                      rts_level;
  logic [`MFS_W-1:0]         min_frame_spacing;
  logic [`REG_W-1:0]         rd_word;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign sel = bus_i.addr[`SEL_FIELD_MSB:`SEL_FIELD_LSB]
               == `SEL_MODEM_CTRL;
  assign wr_hit = bus_i.wr && sel;
  assign rd_hit = bus_i.rd && sel;

  assign min_frame_spacing = mode_word_i[`MFS_MSB:`MFS_LSB];

  assign clk_rise = state_reg.c_s2 && !state_reg.c_s3;
  assign clk_fall = !state_reg.c_s2 && state_reg.c_s3;
  assign tx_edge  = state_reg.ctrl.tx_edge ? clk_rise : clk_fall;

  assign cts_low = !state_reg.b_s2;

  assign release_req = closing_flag_i &&
                       (!frame_waiting_i || spacing_over_two(min_frame_spacing));

  // With handshake on, transmission may start only once clear is granted; with it off, always permitted
  assign permit = !state_reg.ctrl.hs_en ||
                  (state_reg.hs == modem_control_pkg::HS_SEND);

  // Request is active low while asking or sending
  assign rts_level = (state_reg.hs == modem_control_pkg::HS_IDLE);

  // Readback: reserved bits read zero
  always_comb begin
    rd_word = '0;
    rd_word[`BIT_TX_EDGE] = state_reg.ctrl.tx_edge;
    rd_word[`BIT_HS_EN]   = state_reg.ctrl.hs_en;
    rd_word[`BIT_DTR_DIR] = state_reg.ctrl.dtr_dir;
    rd_word[`BIT_DSR_DIR] = state_reg.ctrl.dsr_dir;
    rd_word[`BIT_DTR_VAL] = pick_pin(state_reg.ctrl.dtr_dir,
                                     state_reg.ctrl.dtr_val,
                                     state_reg.a_s2);
    rd_word[`BIT_DSR_VAL] = pick_pin(state_reg.ctrl.dsr_dir,
                                     state_reg.ctrl.dsr_val,
                                     state_reg.b_s2);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // Two-flop synchronisers; third stage for edge detect
    state_next.a_s1 = pin_a_i;
    state_next.a_s2 = state_reg.a_s1;
    state_next.b_s1 = pin_b_i;
    state_next.b_s2 = state_reg.b_s1;
    state_next.c_s1 = tx_clock_i;
    state_next.c_s2 = state_reg.c_s1;
    state_next.c_s3 = state_reg.c_s2;

    // Register writes; reserved bits are not stored
    if (wr_hit) begin
      state_next.ctrl.tx_edge = bus_i.wdata[`BIT_TX_EDGE];
      state_next.ctrl.hs_en   = bus_i.wdata[`BIT_HS_EN];
      state_next.ctrl.dtr_dir = bus_i.wdata[`BIT_DTR_DIR];
      state_next.ctrl.dsr_dir = bus_i.wdata[`BIT_DSR_DIR];
      if (state_reg.ctrl.dtr_dir) begin
        state_next.ctrl.dtr_val = bus_i.wdata[`BIT_DTR_VAL];
      end
      if (state_reg.ctrl.dsr_dir) begin
        state_next.ctrl.dsr_val = bus_i.wdata[`BIT_DSR_VAL];
      end
    end

    // Read data stand for one cycle only
    state_next.rd_data = rd_hit ? rd_word : '0;

    // Handshake sequencer
    case (state_reg.hs)
      modem_control_pkg::HS_IDLE: begin
        if (state_reg.ctrl.hs_en && tx_pending_i) begin
          state_next.hs = modem_control_pkg::HS_REQUEST;
        end
      end
      modem_control_pkg::HS_REQUEST: begin
        if (!state_reg.ctrl.hs_en) begin
          state_next.hs = modem_control_pkg::HS_IDLE;
        end else if (cts_low) begin
          state_next.hs = modem_control_pkg::HS_SEND;
        end
      end
      modem_control_pkg::HS_SEND: begin
        if (!state_reg.ctrl.hs_en || release_req) begin
          state_next.hs = modem_control_pkg::HS_IDLE;
        end
      end
      default: begin
        state_next.hs = modem_control_pkg::HS_IDLE;
      end
    endcase

    // Pin drive
    if (state_reg.ctrl.hs_en) begin
      state_next.pin_a.oe = 1'b1;
      state_next.pin_a.o  = rts_level;
      state_next.pin_b.oe = 1'b0;
      state_next.pin_b.o  = 1'b0;
    end else begin
      state_next.pin_a.oe = state_reg.ctrl.dtr_dir;
      state_next.pin_a.o  = state_reg.ctrl.dtr_dir &&
                            state_reg.ctrl.dtr_val;
      state_next.pin_b.oe = state_reg.ctrl.dsr_dir;
      state_next.pin_b.o  = state_reg.ctrl.dsr_dir &&
                            state_reg.ctrl.dsr_val;
    end

    // Serial data changes on the selected transmit clock edge, and is forced high whenever transmission is not permitted
    if (tx_edge) begin
      state_next.tx_data = permit ? tx_bit_i : 1'b1;
    end else if (!permit) begin
      state_next.tx_data = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg          <= '0;
      state_reg.ctrl     <= `CTRL_RESET;
      state_reg.hs       <= modem_control_pkg::HS_IDLE;
      state_reg.tx_data  <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_o        = state_reg.rd_data;
  assign serial_tx_data_o = state_reg.tx_data;
  assign pin_a_o          = state_reg.pin_a.o;
  assign pin_a_oe_o       = state_reg.pin_a.oe;
  assign pin_b_o          = state_reg.pin_b.o;
  assign pin_b_oe_o       = state_reg.pin_b.oe;
  assign tx_permit_o      = permit;
  assign tx_bit_taken_o   = tx_edge && permit;

endmodule

`default_nettype wire

// >>> shared/modem_control_map.svh
/*
  Register map and fixed numbers for the modem-control lines block.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef MODEM_CONTROL_MAP_SVH
`define MODEM_CONTROL_MAP_SVH

// ----------------------------------------------------------------
// Register select
// ----------------------------------------------------------------
`define SEL_PTR_W        4
`define SEL_FIELD_MSB    3
`define SEL_FIELD_LSB    1
`define SEL_MODEM_CTRL   3'h5

// ----------------------------------------------------------------
// Register fields
// ----------------------------------------------------------------
`define REG_W            16
`define BIT_TX_EDGE      5
`define BIT_HS_EN        4
`define BIT_DTR_DIR      3
`define BIT_DSR_DIR      2
`define BIT_DTR_VAL      1
`define BIT_DSR_VAL      0
`define RESERVED_MSB     15
`define RESERVED_LSB     6
`define CTRL_RESET       6'h00

// ----------------------------------------------------------------
// Mode word spacing field and its codes
// ----------------------------------------------------------------
`define MFS_MSB          15
`define MFS_LSB          11
`define MFS_W            5
`define MFS_CODE_ONE     5'h01
`define MFS_CODE_TWO     5'h00

`endif

// >>> shared/modem_control_pkg.sv
/*
  Types for the modem-control lines block.
  Assumes modem_control_map.svh is on the include path.
*/
`include "modem_control_map.svh"
`default_nettype none

package modem_control_pkg;

  // Handshake sequencer, one-hot
  typedef enum logic [2:0] {
    HS_IDLE    = 3'b001,
    HS_REQUEST = 3'b010,
    HS_SEND    = 3'b100
  } hs_state_t;

  // Register port request
  typedef struct packed {
    logic [`SEL_PTR_W-1:0] addr;
    logic [`REG_W-1:0]     wdata;
    logic                  wr;
    logic                  rd;
  } bus_req_t;

  // Two-way pin drive
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drv_t;

  // Software control bits
  typedef struct packed {
    logic tx_edge;
    logic hs_en;
    logic dtr_dir;
    logic dsr_dir;
    logic dtr_val;
    logic dsr_val;
  } ctrl_t;

  // Whole state of the block
  typedef struct packed {
    ctrl_t             ctrl;
    logic              a_s1;
    logic              a_s2;
    logic              b_s1;
    logic              b_s2;
    logic              c_s1;
    logic              c_s2;
    logic              c_s3;
    hs_state_t         hs;
    pin_drv_t          pin_a;
    pin_drv_t          pin_b;
    logic              tx_data;
    logic [`REG_W-1:0] rd_data;
  } state_t;

endpackage

`default_nettype wire

// >>> sim/modem_control_lines_sva.sv
/* Port assertions for the modem-control block.
   Assumes a bind from the bench onto the top module. */
`default_nettype none
module modem_control_lines_sva (
  input wire logic                        clock_i,
  input wire logic                        rst_n_i,
  input wire modem_control_pkg::bus_req_t bus_i,
  input wire logic [15:0]                 rd_data_o,
  input wire logic                        tx_permit_o,
  input wire logic                        serial_tx_data_o,
  input wire logic                        pin_a_o,
  input wire logic                        pin_a_oe_o,
  input wire logic                        pin_b_o,
  input wire logic                        pin_b_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sel;
  logic wr;
  assign sel = bus_i.addr[3:1] == 3'h5;
  assign wr = bus_i.wr && sel;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_read_unsel: assert property (
    !(bus_i.rd && sel) |=> rd_data_o == 16'h0000)
    else $error("read data without a selected read");
  a_reserved_zero: assert property (
    rd_data_o[15:6] == 10'h000) else $error("reserved bits set");
  a_hs_pins: assert property (
    wr && bus_i.wdata[4] ##1 !wr |=> pin_a_oe_o && !pin_b_oe_o)
    else $error("handshake pin directions wrong");
  a_dtr_output: assert property (
    wr && bus_i.wdata[4:3] == 2'b01 ##1 !wr |=> pin_a_oe_o)
    else $error("terminal-ready pin not driven");
  a_dtr_input: assert property (
    wr && bus_i.wdata[4:3] == 2'b00 ##1 !wr |=> !pin_a_oe_o)
    else $error("terminal-ready pin driven as input");
  a_dsr_drive: assert property (
    !wr ##1 wr && !bus_i.wdata[4] && bus_i.wdata[2] && pin_b_oe_o ##1 !wr
    |=> pin_b_oe_o && pin_b_o == $past(bus_i.wdata[0], 2))
    else $error("set-ready pin value wrong");
  a_idle_high: assert property (
    !tx_permit_o |=> serial_tx_data_o) else $error("data low unpermitted");
  a_permit_off: assert property (
    wr && !bus_i.wdata[4] ##1 !wr |=> tx_permit_o)
    else $error("transmit blocked with handshake off");
endmodule
`default_nettype wire

// >>> sim/modem_equipment_model.sv
/* Far-end modem equipment: line levels and transmit clock.
   Assumes the bench drives its inputs at the clock edge. */
`default_nettype none
module modem_equipment_model (
  input  wire logic clock_i,
  input  wire logic run_i,
  input  wire logic grant_i,
  input  wire logic far_a_i,
  input  wire logic far_b_i,
  input  wire logic dev_a_i,
  input  wire logic dev_a_oe_i,
  input  wire logic dev_b_i,
  input  wire logic dev_b_oe_i,
  output logic      line_a_o,
  output logic      line_b_o,
  output logic      tx_clock_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] phase = 4'h0;
  // Device drive wins, else the far end sets the level
  assign line_a_o = dev_a_oe_i ? dev_a_i : far_a_i;
  // Undriven, clear is low while request is low and the far end grants, or while far_b is low
  assign line_b_o = dev_b_oe_i ? dev_b_i
                  : far_b_i & ~(grant_i & ~line_a_o);
  // Transmit clock runs free once the bench starts it
  assign tx_clock_o = phase[3];
  always @(posedge clock_i) begin
    if (run_i) phase <= phase + 4'h1;
  end
endmodule
`default_nettype wire

// >>> sim/test_modem_control_lines.sv
/* Self-checking bench for the modem-control block.
   Assumes package, checker and equipment model compiled first. */
`default_nettype none
`define check(g, e) begin num_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("unexpected %0t %h %h", $time, g, e); end end
module test_modem_control_lines;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'b0, rst_n_i = 1'b0;
  modem_control_pkg::bus_req_t bus = '0;
  logic [15:0] rd_data_o, mode = 16'h0000;
  logic tx_bit = 1'b1, pend = 1'b0, closing = 1'b0, waiting = 1'b0;
  logic permit, tx_clock, serial, a_i, a_o, a_oe, b_i, b_o, b_oe, taken;
  logic far_a = 1'b1, far_b = 1'b0, grant = 1'b0, run = 1'b0;
  int n_mismatch = 0, num_checks = 0, cycles = 0, n_taken = 0;
  modem_control_lines uut (.clock_i, .rst_n_i, .bus_i(bus), .rd_data_o,
    .tx_bit_i(tx_bit), .tx_pending_i(pend), .closing_flag_i(closing),
    .frame_waiting_i(waiting), .mode_word_i(mode), .tx_permit_o(permit),
    .tx_bit_taken_o(taken), .tx_clock_i(tx_clock), .serial_tx_data_o(serial),
    .pin_a_i(a_i), .pin_a_o(a_o), .pin_a_oe_o(a_oe), .pin_b_i(b_i),
    .pin_b_o(b_o), .pin_b_oe_o(b_oe));
  modem_equipment_model eq (.clock_i, .run_i(run), .grant_i(grant),
    .far_a_i(far_a), .far_b_i(far_b), .dev_a_i(a_o), .dev_a_oe_i(a_oe),
    .dev_b_i(b_o), .dev_b_oe_i(b_oe), .line_a_o(a_i), .line_b_o(b_i),
    .tx_clock_o(tx_clock));
  always #12.5 clock_i = ~clock_i;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock_i);
    bus.rd <= 1'b0;
    #1 `check(rd_data_o, e)
  endtask
  task automatic frame(input logic w, input logic [4:0] c, input logic r);
    @(posedge clock_i);
    waiting <= w;
    mode <= {c, 11'h000};
    repeat (12) @(posedge clock_i);
    #1 `check({a_o, permit}, 2'b01)
    @(posedge clock_i);
    closing <= 1'b1;
    pend <= w;
    @(posedge clock_i);
    closing <= 1'b0;
    @(posedge clock_i);
    #1 `check(a_o, r)
  endtask
  task automatic edge_case(input logic rise);
    int t0;
    wr(4'hA, {10'h000, rise, 5'h00});
    tx_bit <= 1'b1;
    repeat (2) begin
      wait (tx_clock);
      wait (!tx_clock);
    end
    t0 = n_taken;
    repeat (6) @(posedge clock_i);
    tx_bit <= 1'b0;
    repeat (9) @(posedge clock_i);
    #1 `check(serial, ~rise)
    `check(n_taken - t0, 1)
  endtask
  task automatic test_registers;
    wr(4'hA, 16'h0000);
    wr(4'h4, 16'h003C);
    rd_chk(4'hB, 16'h0002);
    rd_chk(4'h8, 16'h0000);
    @(posedge clock_i);
    far_a <= 1'b0;
    far_b <= 1'b1;
    repeat (4) @(posedge clock_i);
    rd_chk(4'hA, 16'h0001);
    $display("register test done");
  endtask
  task automatic test_pins;
    wr(4'hA, 16'h000F);
    @(posedge clock_i);
    #1 `check({a_oe, a_o, b_oe, b_o}, 4'b1010)
    wr(4'hA, 16'h000E);
    rd_chk(4'hA, 16'h000E);
    `check({a_o, b_o, a_i, b_i}, 4'b1010)
    wr(4'hA, 16'h000D);
    rd_chk(4'hA, 16'h000D);
    `check({a_o, b_o}, 2'b01)
    wr(4'hA, 16'h0008);
    rd_chk(4'hA, 16'h0009);
    $display("pin test done");
  endtask
  task automatic test_handshake;
    wr(4'hA, 16'h001C);
    @(posedge clock_i);
    #1 `check({a_oe, a_o, b_oe, permit}, 4'b1100)
    rd_chk(4'hA, 16'h001C);
    @(posedge clock_i);
    run <= 1'b1;
    pend <= 1'b1;
    repeat (10) @(posedge clock_i);
    #1 `check({a_o, permit, serial}, 3'b001)
    @(posedge clock_i);
    grant <= 1'b1;
    frame(1'b1, 5'h01, 1'b0);
    frame(1'b1, 5'h00, 1'b0);
    frame(1'b1, 5'h02, 1'b1);
    frame(1'b0, 5'h01, 1'b1);
    $display("handshake test done");
  endtask
  task automatic test_edges;
    edge_case(1'b1);
    edge_case(1'b0);
    $display("edge test done");
  endtask
  // ----------------------------------------------------------------
  // Run
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (taken) n_taken <= n_taken + 1;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    test_registers;
    test_pins;
    test_handshake;
    test_edges;
    give_verdict;
  end
endmodule
bind modem_control_lines modem_control_lines_sva chk (.clock_i, .rst_n_i,
  .bus_i, .rd_data_o, .tx_permit_o, .serial_tx_data_o, .pin_a_o,
  .pin_a_oe_o, .pin_b_o, .pin_b_oe_o);
`default_nettype wire
